// File: verilog/swd_seconds_watchdog.sv
`timescale 1ns/1ps
// ============================================================================
// Seconds watchdog with a classic Wishbone register slave.
// What this block does
// - Control bit 7 interrupt enable, bits 6-4 line
// - Control bit 3 ignores writes, reads zero
// - Bit 2 set: expiry asserts board reset
// - Bit 0 reads expiry, zero while disabled
// - Expiry sticks until non-zero timeout write, disable, reset
// - Timeout is 8-bit read/write seconds remaining
// - Enabled watchdog fires when timeout is zero
// - Timeout resets to zero; enabling fires immediately
// - Each timeout write reloads the countdown
// - Countdown steps on free-running one-second tick
// - Reset returns both registers to defaults
module swd_seconds_watchdog #(
    parameter int TICK_CYCLES = swd_pkg::TICK_CYCLES_DEFAULT
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [swd_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [swd_pkg::DAT_W-1:0] dat_i,
    output logic [swd_pkg::DAT_W-1:0] dat_o,
    output logic ack_o,
    output logic [swd_pkg::IRQ_LINES-1:0] serialIrqLines,
    output logic boardReset,
    output logic interrupt
);
    // ========================================================================
    // Register bus.
    logic ack_ff;
    logic [swd_pkg::DAT_W-1:0] rdData_ff;
    logic busWrite;
    logic ctrlWrite;
    logic timeoutWrite;
    logic clearWrite;
    logic enableWrite;
    logic [swd_pkg::REG_W-1:0] wrByte;
    logic [swd_pkg::REG_W-1:0] rdByte;

    logic interruptEnable_ff;
    logic [2:0] interruptLineSelect_ff;
    logic resetEnable_ff;
    logic timerEnable_ff;
    logic expiredFlag_ff;
    logic [swd_pkg::REG_W-1:0] timeoutSeconds_ff;
    logic [swd_pkg::EVT_W-1:0] intStatus_ff;
    logic [swd_pkg::EVT_W-1:0] intEnable_ff;
    logic boardReset_ff;
    logic interrupt_ff;

    logic nxt_timerEnable;
    logic [swd_pkg::REG_W-1:0] nxt_timeoutSeconds;
    logic nxt_expiredFlag;
    logic secondTick;
    logic [swd_pkg::REG_W-1:0] controlView;

    // A write commits at the edge that samples ack high, matching the master.
    assign busWrite = cyc_i && stb_i && we_i && ack_ff && sel_i[0];
    assign wrByte = dat_i[swd_pkg::REG_W-1:0];
    assign ctrlWrite = busWrite && (adr_i == swd_pkg::ADR_CONTROL);
    assign timeoutWrite = busWrite && (adr_i == swd_pkg::ADR_TIMEOUT);
    assign clearWrite = busWrite && (adr_i == swd_pkg::ADR_INT_CLEAR);
    assign enableWrite = busWrite && (adr_i == swd_pkg::ADR_INT_ENABLE);

    always_comb begin
        controlView = '0;
        controlView[swd_pkg::CTL_INT_ENABLE] = interruptEnable_ff;
        controlView[swd_pkg::CTL_LINE_SEL_HI:swd_pkg::CTL_LINE_SEL_LO] = interruptLineSelect_ff;
        controlView[swd_pkg::CTL_RESERVED] = 1'b0;
        controlView[swd_pkg::CTL_RESET_ENABLE] = resetEnable_ff;
        controlView[swd_pkg::CTL_TIMER_ENABLE] = timerEnable_ff;
        controlView[swd_pkg::CTL_EXPIRED] = expiredFlag_ff;
    end

    // Unmapped addresses and the write-only clear register read as zero.
    always_comb begin
        unique case (adr_i)
            swd_pkg::ADR_CONTROL: rdByte = controlView;
            swd_pkg::ADR_TIMEOUT: rdByte = timeoutSeconds_ff;
            swd_pkg::ADR_INT_STATUS: rdByte = swd_pkg::REG_W'(intStatus_ff);
            swd_pkg::ADR_INT_ENABLE: rdByte = swd_pkg::REG_W'(intEnable_ff);
            default: rdByte = '0;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= cyc_i && stb_i && !ack_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            rdData_ff <= '0;
        end else if (cyc_i && stb_i && !ack_ff && !we_i) begin
            rdData_ff <= swd_pkg::DAT_W'(rdByte);
        end else begin
            rdData_ff <= '0;
        end
    end

    // ========================================================================
    // Control register.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            interruptEnable_ff <= 1'b0;
            interruptLineSelect_ff <= swd_pkg::LINE_SEL_RESET;
            resetEnable_ff <= 1'b0;
        end else if (ctrlWrite) begin
            interruptEnable_ff <= wrByte[swd_pkg::CTL_INT_ENABLE];
            interruptLineSelect_ff <= wrByte[swd_pkg::CTL_LINE_SEL_HI:swd_pkg::CTL_LINE_SEL_LO];
            resetEnable_ff <= wrByte[swd_pkg::CTL_RESET_ENABLE];
        end
    end

    assign nxt_timerEnable = ctrlWrite ? wrByte[swd_pkg::CTL_TIMER_ENABLE] : timerEnable_ff;

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            timerEnable_ff <= 1'b0;
        end else begin
            timerEnable_ff <= nxt_timerEnable;
        end
    end

    // ========================================================================
    // Countdown.
    swd_tick_divider #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .mclk(mclk),
        .reset_n(reset_n),
        .tick(secondTick)
    );

    // A reload beats a tick that lands in the same cycle.
    always_comb begin
        nxt_timeoutSeconds = timeoutSeconds_ff;
        if (timeoutWrite) begin
            nxt_timeoutSeconds = wrByte;
        end else if (timerEnable_ff && secondTick && (timeoutSeconds_ff != '0)) begin
            nxt_timeoutSeconds = timeoutSeconds_ff - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            timeoutSeconds_ff <= swd_pkg::TIMEOUT_RESET;
        end else begin
            timeoutSeconds_ff <= nxt_timeoutSeconds;
        end
    end

    // The set term looks at next values, so a reload of a non-zero count clears
    // the flag at once, while reloading zero keeps it set.
    always_comb begin
        nxt_expiredFlag = expiredFlag_ff && !timeoutWrite && nxt_timerEnable;
        if (nxt_timerEnable && (nxt_timeoutSeconds == '0)) begin
            nxt_expiredFlag = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            expiredFlag_ff <= 1'b0;
        end else begin
            expiredFlag_ff <= nxt_expiredFlag;
        end
    end

    // ========================================================================
    // Outputs of an expiry.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            boardReset_ff <= 1'b0;
        end else begin
            boardReset_ff <= resetEnable_ff && expiredFlag_ff;
        end
    end

    swd_irq_map u_irq_map (
        .mclk(mclk),
        .reset_n(reset_n),
        .request(interruptEnable_ff && expiredFlag_ff),
        .lineSel(interruptLineSelect_ff),
        .lines(serialIrqLines)
    );

    // ========================================================================
    // Local interrupt status, enable and clear.
    logic [swd_pkg::EVT_W-1:0] events;

    always_comb begin
        events = '0;
        events[swd_pkg::EVT_EXPIRED] = nxt_expiredFlag && !expiredFlag_ff;
        events[swd_pkg::EVT_RELOAD] = timeoutWrite;
    end

    // A new event wins over a clear written in the same cycle.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            intStatus_ff <= swd_pkg::EVT_RESET;
        end else begin
            intStatus_ff <= events | (intStatus_ff & ~(clearWrite ? wrByte[swd_pkg::EVT_W-1:0] : '0));
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            intEnable_ff <= swd_pkg::EVT_RESET;
        end else if (enableWrite) begin
            intEnable_ff <= wrByte[swd_pkg::EVT_W-1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            interrupt_ff <= 1'b0;
        end else begin
            interrupt_ff <= |(intStatus_ff & intEnable_ff);
        end
    end

    assign dat_o = rdData_ff;
    assign ack_o = ack_ff;
    assign boardReset = boardReset_ff;
    assign interrupt = interrupt_ff;

    // ========================================================================
    // Checks.
    AST_CTL_RESERVED_ZERO: assert property (@(posedge mclk) disable iff (!reset_n)
        (cyc_i && stb_i && !we_i && !ack_ff && adr_i == swd_pkg::ADR_CONTROL)
        |=> (dat_o[swd_pkg::CTL_RESERVED] == 1'b0) && ack_o)
        else $error("Reserved control bit read as one.");

    AST_FIRE_ON_ZERO: assert property (@(posedge mclk) disable iff (!reset_n)
        (timerEnable_ff && timeoutSeconds_ff == '0 && !busWrite) |=> expiredFlag_ff)
        else $error("Enabled watchdog at zero did not fire.");

    AST_DISABLED_QUIET: assert property (@(posedge mclk) disable iff (!reset_n)
        !timerEnable_ff |-> !expiredFlag_ff ##1 !boardReset_ff && serialIrqLines == '0)
        else $error("Disabled watchdog shows an expiry.");

    AST_FLAG_STICKY: assert property (@(posedge mclk) disable iff (!reset_n)
        (expiredFlag_ff && !timeoutWrite && !(ctrlWrite && !wrByte[swd_pkg::CTL_TIMER_ENABLE]))
        |=> expiredFlag_ff)
        else $error("Expired flag dropped without cause.");

    AST_BOARD_RESET: assert property (@(posedge mclk) disable iff (!reset_n)
        (resetEnable_ff && expiredFlag_ff) |=> boardReset_ff ##0 (boardReset_ff == $past(
        resetEnable_ff)))
        else $error("Board reset did not follow expiry.");

    AST_LINE_TEN: assert property (@(posedge mclk) disable iff (!reset_n)
        (interruptEnable_ff && expiredFlag_ff && interruptLineSelect_ff == 3'h3)
        |=> serialIrqLines == 16'h0400)
        else $error("Select code three did not drive line ten.");

    AST_IRQ_HELD: assert property (@(posedge mclk) disable iff (!reset_n)
        (interruptEnable_ff && expiredFlag_ff)[*2] |-> $onehot(serialIrqLines))
        else $error("Interrupt request not held during expiry.");

    AST_RELOAD: assert property (@(posedge mclk) disable iff (!reset_n)
        timeoutWrite |=> timeoutSeconds_ff == $past(dat_i[swd_pkg::REG_W-1:0]))
        else $error("Timeout write did not reload the count.");

    AST_STEP: assert property (@(posedge mclk) disable iff (!reset_n)
        (timerEnable_ff && secondTick && timeoutSeconds_ff != '0 && !timeoutWrite)
        |=> timeoutSeconds_ff == $past(timeoutSeconds_ff) - 8'h01)
        else $error("Countdown did not step on the tick.");

    AST_HOLD: assert property (@(posedge mclk) disable iff (!reset_n)
        (!timerEnable_ff && !timeoutWrite) |=> $stable(timeoutSeconds_ff))
        else $error("Disabled countdown moved.");

    AST_RESET_DEFAULTS: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(reset_n) |-> controlView == '0 && timeoutSeconds_ff == '0)
        else $error("Registers not at defaults after reset.");

    AST_ACK_ONE: assert property (@(posedge mclk) disable iff (!reset_n)
        ack_o |=> !ack_o)
        else $error("Acknowledge held longer than one cycle.");

    // The host commits on the answer edge, so the answer must come exactly one cycle late.
    AST_ACK_AFTER_REQ: assert property (@(posedge mclk) disable iff (!reset_n)
        (cyc_i && stb_i && !ack_o) |=> ack_o)
        else $error("Request not acknowledged in the next cycle.");

    AST_DATA_IDLE_ZERO: assert property (@(posedge mclk) disable iff (!reset_n)
        !ack_o |-> dat_o == '0)
        else $error("Read data not zero outside the acknowledge cycle.");

    AST_DISABLE_CLEARS: assert property (@(posedge mclk) disable iff (!reset_n)
        (ctrlWrite && !wrByte[swd_pkg::CTL_TIMER_ENABLE])
        |=> !expiredFlag_ff && !timerEnable_ff)
        else $error("Clearing the enable left the expired flag set.");

    AST_KICK_CLEARS: assert property (@(posedge mclk) disable iff (!reset_n)
        (timeoutWrite && wrByte != '0) |=> !expiredFlag_ff)
        else $error("Non-zero timeout write left the expired flag set.");

    AST_FLAG_NEEDS_EN: assert property (@(posedge mclk) disable iff (!reset_n)
        expiredFlag_ff |-> timerEnable_ff)
        else $error("Expired flag set while the watchdog was disabled.");

    AST_RESET_OFF_QUIET: assert property (@(posedge mclk) disable iff (!reset_n)
        !resetEnable_ff |=> !boardReset_ff)
        else $error("Board reset asserted while reset enable was clear.");

    AST_IRQ_OFF_QUIET: assert property (@(posedge mclk) disable iff (!reset_n)
        !interruptEnable_ff |=> serialIrqLines == '0)
        else $error("Serial line requested while interrupts were disabled.");

    AST_ONE_LINE: assert property (@(posedge mclk) disable iff (!reset_n)
        $onehot0(serialIrqLines))
        else $error("More than one serial line requested.");

    AST_EVENT_SETS_STATUS: assert property (@(posedge mclk) disable iff (!reset_n)
        events[swd_pkg::EVT_EXPIRED] |=> intStatus_ff[swd_pkg::EVT_EXPIRED])
        else $error("Expiry event lost against a clear.");

    AST_INT_LEVEL: assert property (@(posedge mclk) disable iff (!reset_n)
        (|(intStatus_ff & intEnable_ff)) |=> interrupt_ff)
        else $error("Enabled status bit did not raise the interrupt.");

    COV_EXPIRY: cover property (@(posedge mclk) disable iff (!reset_n)
        timerEnable_ff && secondTick && timeoutSeconds_ff == 8'h01 ##1 expiredFlag_ff);
    COV_KICK_CLEARS: cover property (@(posedge mclk) disable iff (!reset_n)
        expiredFlag_ff && timeoutWrite ##1 !expiredFlag_ff);
    COV_BOARD_RESET: cover property (@(posedge mclk) disable iff (!reset_n)
        $rose(boardReset_ff));
    COV_INTERRUPT: cover property (@(posedge mclk) disable iff (!reset_n)
        $rose(interrupt_ff));
    COV_LINE_ELEVEN: cover property (@(posedge mclk) disable iff (!reset_n)
        serialIrqLines[11]);

endmodule : swd_seconds_watchdog

// File: pkg/swd_pkg.sv
// ============================================================================
// Shared constants of the seconds watchdog.
package swd_pkg;

    // ========================================================================
    // Timing.
    localparam int CLOCK_HZ = 10_000_000;
    localparam int TICK_PERIOD_MS = 1000;
    localparam int TICK_CYCLES_DEFAULT = CLOCK_HZ / 1000 * TICK_PERIOD_MS;
    localparam int TICK_CNT_W = 24;

    // ========================================================================
    // Bus layout.
    localparam int ADR_W = 8;
    localparam int DAT_W = 32;
    localparam int REG_W = 8;
    localparam logic [ADR_W-1:0] ADR_CONTROL = 8'h00;
    localparam logic [ADR_W-1:0] ADR_TIMEOUT = 8'h04;
    localparam logic [ADR_W-1:0] ADR_INT_STATUS = 8'h08;
    localparam logic [ADR_W-1:0] ADR_INT_CLEAR = 8'h0C;
    localparam logic [ADR_W-1:0] ADR_INT_ENABLE = 8'h10;

    // ========================================================================
    // Control register fields.
    localparam int CTL_INT_ENABLE = 7;
    localparam int CTL_LINE_SEL_HI = 6;
    localparam int CTL_LINE_SEL_LO = 4;
    localparam int CTL_RESERVED = 3;
    localparam int CTL_RESET_ENABLE = 2;
    localparam int CTL_TIMER_ENABLE = 1;
    localparam int CTL_EXPIRED = 0;
    localparam logic [REG_W-1:0] TIMEOUT_RESET = 8'h00;
    localparam logic [2:0] LINE_SEL_RESET = 3'h0;

    // ========================================================================
    // Interrupt event bits.
    localparam int EVT_W = 2;
    localparam int EVT_EXPIRED = 0;
    localparam int EVT_RELOAD = 1;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

    // ========================================================================
    // Serial interrupt lines, indexed by the line select code.
    localparam int IRQ_LINES = 16;
    localparam logic [3:0] IRQ_NUMBER [8] = '{4'h3, 4'h4, 4'h5, 4'hA,
                                             4'h6, 4'h7, 4'h9, 4'hB};

endpackage : swd_pkg

// File: verilog/swd_tick_divider.sv
`timescale 1ns/1ps
// ============================================================================
// Free-running divider that pulses once per period.
module swd_tick_divider #(
    parameter int TICK_CYCLES = swd_pkg::TICK_CYCLES_DEFAULT
) (
    input wire logic mclk,
    input wire logic reset_n,
    output logic tick
);
    localparam logic [swd_pkg::TICK_CNT_W-1:0] LAST = swd_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

    logic [swd_pkg::TICK_CNT_W-1:0] count_ff;
    logic tick_ff;

    // The count never aligns to software writes, so each reload loses up to one period.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            count_ff <= '0;
            tick_ff <= 1'b0;
        end else if (count_ff == LAST) begin
            count_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            count_ff <= count_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end

    assign tick = tick_ff;

endmodule : swd_tick_divider

// File: verilog/swd_irq_map.sv
`timescale 1ns/1ps
// ============================================================================
// Turns a line select code into a registered request on one serial line.
module swd_irq_map (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic request,
    input wire logic [2:0] lineSel,
    output logic [swd_pkg::IRQ_LINES-1:0] lines
);
    logic [swd_pkg::IRQ_LINES-1:0] lines_ff;

    genvar i;
    generate
        for (i = 0; i < swd_pkg::IRQ_LINES; i++) begin : g_line
            always_ff @(posedge mclk) begin
                if (!reset_n) begin
                    lines_ff[i] <= 1'b0;
                end else begin
                    lines_ff[i] <= request && (swd_pkg::IRQ_NUMBER[lineSel] == 4'(i));
                end
            end
        end
    endgenerate

    assign lines = lines_ff;

endmodule : swd_irq_map

// File: test/swd_host_model.sv
`timescale 1ns/1ps
// ============================================================================
// Host side of the register bus: one classic Wishbone cycle per call.
module swd_host_model (
    input wire logic mclk,
    input wire logic ackI,
    input wire logic [swd_pkg::DAT_W-1:0] datI,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [swd_pkg::ADR_W-1:0] adr,
    output logic [3:0] sel,
    output logic [swd_pkg::DAT_W-1:0] wdat
);
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'h0;
        wdat = 32'h0;
    end

    // The wait has no cap of its own; the bench's cycle ceiling ends a hang.
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hF;
        wdat <= d;
        do begin
            @(posedge mclk);
        end while (ackI !== 1'b1);
        r = datI;
        // Released lines show garbage so stale values are never trusted.
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        adr <= ~a;
        wdat <= ~d;
    endtask : xfer
endmodule : swd_host_model

// File: test/tb_top.sv
`timescale 1ns/1ps
// ============================================================================
// Self-checking bench for the seconds watchdog.
module tb_top;
    localparam int TCYC = 20;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cyc, stb, we, ack, boardReset, interrupt;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] wdat, rdatO, rdat;
    logic [15:0] lines;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int irqQ[$] = '{3, 4, 5, 10, 6, 7, 9, 11};
    int to, t0, el;
    logic [7:0] v;

    always #50 mclk = ~mclk;

    swd_seconds_watchdog #(.TICK_CYCLES(TCYC)) uut (.mclk(mclk), .reset_n(reset_n),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdatO), .ack_o(ack), .serialIrqLines(lines), .boardReset(boardReset),
        .interrupt(interrupt));
    swd_host_model host (.mclk(mclk), .ackI(ack), .datI(rdatO), .cyc(cyc), .stb(stb),
        .we(we), .adr(adr), .sel(sel), .wdat(wdat));

    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 4000) begin
            bad_count++;
            final_report();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch reg at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_pin(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch pin at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rdat);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0, rdat);
        chk_reg(rdat, exp);
    endtask : rd

    task automatic hold_reset();
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
    endtask : hold_reset

    initial begin
        void'($urandom(89));
        hold_reset();
        rd(swd_pkg::ADR_CONTROL, 32'h0);
        rd(swd_pkg::ADR_TIMEOUT, 32'h0);
        rd(8'h40, 32'h0);
        rd(swd_pkg::ADR_INT_STATUS, 32'h0);
        chk_pin({lines[15:1], boardReset}, 16'h0);
        $display("test reset values done");
        wr(swd_pkg::ADR_CONTROL, 32'h7D);
        rd(swd_pkg::ADR_CONTROL, 32'h74);
        to = 2 + ($urandom % 254);
        wr(swd_pkg::ADR_TIMEOUT, 32'(to));
        repeat (3 * TCYC) @(posedge mclk);
        rd(swd_pkg::ADR_TIMEOUT, 32'(to));
        chk_pin({15'h0, boardReset}, 16'h0);
        wr(swd_pkg::ADR_TIMEOUT, 32'h0);
        wr(swd_pkg::ADR_INT_CLEAR, 32'h3);
        $display("test fields and hold done");
        for (int c = 0; c < 8; c++) begin
            v = {1'b1, 3'(c), 1'b0, 1'(c), 2'b10};
            wr(swd_pkg::ADR_CONTROL, 32'(v));
            repeat (3) @(posedge mclk);
            rd(swd_pkg::ADR_CONTROL, 32'(v | 8'h01));
            chk_pin(lines, 16'h1 << irqQ[c]);
            chk_pin({15'h0, boardReset}, 16'(c % 2));
            wr(swd_pkg::ADR_CONTROL, 32'(v & 8'hFD));
            repeat (3) @(posedge mclk);
            rd(swd_pkg::ADR_CONTROL, 32'(v & 8'hFC));
            chk_pin({lines[15:1], lines[0] | boardReset}, 16'h0);
        end
        $display("test line select and expiry done");
        rd(swd_pkg::ADR_INT_STATUS, 32'h1);
        wr(swd_pkg::ADR_INT_ENABLE, 32'h1);
        repeat (2) @(posedge mclk);
        chk_pin({15'h0, interrupt}, 16'h1);
        wr(swd_pkg::ADR_INT_ENABLE, 32'h0);
        repeat (2) @(posedge mclk);
        chk_pin({15'h0, interrupt}, 16'h0);
        wr(swd_pkg::ADR_INT_CLEAR, 32'h1);
        rd(swd_pkg::ADR_INT_STATUS, 32'h0);
        rd(swd_pkg::ADR_INT_CLEAR, 32'h0);
        $display("test interrupt registers done");
        wr(swd_pkg::ADR_TIMEOUT, 32'h3);
        rd(swd_pkg::ADR_INT_STATUS, 32'h2);
        t0 = cycles;
        wr(swd_pkg::ADR_CONTROL, 32'h86);
        do begin
            host.xfer(1'b0, swd_pkg::ADR_CONTROL, 32'h0, rdat);
        end while (rdat[0] !== 1'b1 && cycles - t0 < 4 * TCYC + 20);
        el = cycles - t0;
        chk_reg(32'(el >= 2 * TCYC), 32'h1);
        chk_reg(32'(el <= 3 * TCYC + 10), 32'h1);
        rd(swd_pkg::ADR_TIMEOUT, 32'h0);
        wr(swd_pkg::ADR_TIMEOUT, 32'h3);
        rd(swd_pkg::ADR_CONTROL, 32'h86);
        repeat (6) begin
            wr(swd_pkg::ADR_TIMEOUT, 32'h3);
            repeat (TCYC - 4) @(posedge mclk);
            rd(swd_pkg::ADR_CONTROL, 32'h86);
        end
        $display("test countdown and reload done");
        hold_reset();
        rd(swd_pkg::ADR_CONTROL, 32'h0);
        rd(swd_pkg::ADR_TIMEOUT, 32'h0);
        chk_pin({lines[15:1], lines[0] | boardReset}, 16'h0);
        $display("test mid-run reset done");
        final_report();
    end
endmodule : tb_top
